/* File: bench/scp_host.sv */
// host model driving the serial control link
`timescale 1ns/100ps
module scp_host (
   // serial link
   output logic      SCLK,
   output logic      SEL_N,
   output logic      SDI,
   input  wire logic SDO
);
   initial begin
      SCLK = 1'b0; // stands still outside frames
      SEL_N = 1'b1;
      SDI = 1'b0;
   end
   // nbits below 16 gives a short frame on purpose
   task automatic frame(input logic [15:0] tx, input int nbits,
                        output logic [15:0] rx);
      rx = 16'h0000;
      SEL_N = 1'b0;
      SDI = tx[15];
      #62.5;
      for (int i = 0; i < nbits; i++) begin
         SCLK = 1'b1;
         rx = {rx[14:0], SDO};
         #62.5;
         SCLK = 1'b0;
         if (i < 15) SDI = tx[14-i];
         #62.5;
      end
      SEL_N = 1'b1;
      SDI = ~SDI; // released line shows no stale value
      #100;
   endtask
endmodule // scp_host

/* File: bench/scp_port_asserts.sv */
// concurrent checks on the serial control port pins
`timescale 1ns/100ps
module scp_port_asserts (
   // system
   input wire logic CLOCK,
   input wire logic NRST,
   // link and interrupt pins
   input wire logic CONTROL_SHIFT_CLOCK,
   input wire logic SELECT_N,
   input wire logic SERIAL_CMD_OUT,
   input wire logic SERIAL_CMD_OUT_EN,
   input wire logic IRQ_N_OUT,
   input wire logic IRQ_N_OE
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   // long enough for the synchroniser to see select low
   sequence sel_low4;
      !SELECT_N [*4];
   endsequence
   sequence mid_frame;
      !SELECT_N && !$past(SELECT_N) && $stable(CONTROL_SHIFT_CLOCK);
   endsequence
   out_gate_a: assert property (SERIAL_CMD_OUT_EN |-> !SELECT_N)
      else $error("data out driven while select high");
   out_steady_a: assert property (mid_frame |-> $stable(SERIAL_CMD_OUT))
      else $error("data out moved without a falling shift edge");
   irq_pin_a: assert property (!IRQ_N_OUT)
      else $error("interrupt pin value not low");
   irq_release_a: assert property ($fell(SELECT_N) |-> ##[1:4] !IRQ_N_OE)
      else $error("interrupt not released after select fell");
   irq_no_rise_a: assert property (sel_low4 |=> !$rose(IRQ_N_OE))
      else $error("interrupt raised during a frame");
   irq_hold_a: assert property (IRQ_N_OE && SELECT_N && $past(SELECT_N)
      |=> IRQ_N_OE)
      else $error("interrupt dropped before select fell");
   irq_rise_gap_a: assert property ($rose(IRQ_N_OE) |-> $past(SELECT_N))
      else $error("interrupt rose while select was low");
   mode_fixed_a: assert property ($past(SERIAL_CMD_OUT_EN) && !SELECT_N
      |-> SERIAL_CMD_OUT_EN)
      else $error("port mode changed after capture");
endmodule // scp_port_asserts

bind scp_port scp_port_asserts u_chk (.CLOCK(CLOCK), .NRST(NRST),
   .CONTROL_SHIFT_CLOCK(CONTROL_SHIFT_CLOCK), .SELECT_N(SELECT_N),
   .SERIAL_CMD_OUT(SERIAL_CMD_OUT), .SERIAL_CMD_OUT_EN(SERIAL_CMD_OUT_EN),
   .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE));

/* File: bench/scp_port_bench.sv */
// self-checking bench for the serial control port
`timescale 1ns/100ps
module scp_port_bench;
   import scp_pkg::*;
   logic        clock, nrst, mode_pin, st_a, st_b, synced;
   logic        sdo, sdo_en, irq_out, irq_oe;
   wire logic   sclk, sel_n, sdi, co_w, irq_w;
   logic [15:0] rx;
   int          fail_count = 0;
   int          num_checks = 0;

   assign co_w  = sdo_en ? sdo : 1'bz;
   assign irq_w = irq_oe ? irq_out : 1'b1; // pull-up

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   scp_port u_dut (.CLOCK(clock), .NRST(nrst),
      .INTERFACE_SELECT_PIN(mode_pin), .CONTROL_SHIFT_CLOCK(sclk),
      .SELECT_N(sel_n), .SERIAL_CMD_IN(sdi), .SERIAL_CMD_OUT(sdo),
      .SERIAL_CMD_OUT_EN(sdo_en), .IRQ_N_OUT(irq_out), .IRQ_N_OE(irq_oe),
      .EXT_STATUS_IN_A(st_a), .EXT_STATUS_IN_B(st_b), .LINE_SYNCED(synced));
   scp_host u_host (.SCLK(sclk), .SEL_N(sel_n), .SDI(sdi), .SDO(co_w));

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic sync_in;
      @(posedge clock);
      #1;
   endtask
   // bounded wait; exp 1 means a request must show
   task automatic wait_irq(input logic exp);
      repeat (40) begin
         @(posedge clock);
         if (irq_w === 1'b0) break;
      end
      #1;
      chk_bit(irq_w, ~exp);
   endtask
   task automatic xfer(input logic [15:0] tx, input int n);
      u_host.frame(tx, n, rx);
      chk_bit(co_w, 1'bz);
   endtask

   task automatic t_idle;
      xfer({7'h05, RW_WRITE, 8'hA5}, 16);
      chk_word(rx, MSG_ZERO);
      wait_irq(1'b0);
      $display("test idle done");
   endtask
   task automatic t_readback;
      xfer({7'h05, RW_READ, 8'h3C}, 16);
      wait_irq(1'b1);
      xfer(MSG_ZERO, 16);
      chk_word(rx, {7'h05, REPLY_READBACK, 8'hA5});
      wait_irq(1'b0);
      $display("test readback done");
   endtask
   task automatic t_status;
      sync_in;
      mode_pin = 1'b0; // strap no longer sampled
      st_a = 1'b1;
      wait_irq(1'b1);
      xfer(MSG_ZERO, 16);
      chk_word(rx, {MAINT_ADDR, REPLY_SPONT, 8'h01});
      sync_in;
      synced = 1'b0;
      st_b = 1'b1;
      wait_irq(1'b0);
      st_b = 1'b0;
      repeat (8) @(posedge clock);
      #1 synced = 1'b1;
      $display("test status done");
   endtask
   task automatic t_queue;
      sync_in;
      st_a = 1'b0;
      wait_irq(1'b1);
      xfer({7'h05, RW_READ, 8'h00}, 16);
      chk_word(rx, {MAINT_ADDR, REPLY_SPONT, 8'h00});
      wait_irq(1'b1);
      xfer(MSG_ZERO, 16);
      chk_word(rx, {7'h05, REPLY_READBACK, 8'hA5});
      wait_irq(1'b0);
      $display("test queue done");
   endtask
   task automatic t_short;
      xfer({7'h06, RW_WRITE, 8'h77}, 12);
      xfer({7'h06, RW_READ, 8'h00}, 16);
      wait_irq(1'b1);
      xfer(MSG_ZERO, 8);
      chk_word(rx, {8'h00, 7'h06, REPLY_READBACK});
      wait_irq(1'b1);
      xfer(MSG_ZERO, 16);
      chk_word(rx, {7'h06, REPLY_READBACK, REG_RST});
      $display("test short done");
   endtask
   task automatic t_mode0;
      sync_in;
      nrst = 1'b0;
      repeat (10) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (8) @(posedge clock);
      #1 st_a = 1'b1;
      xfer({7'h05, RW_READ, 8'h00}, 16);
      chk_word(rx, 16'hzzzz);
      wait_irq(1'b0);
      $display("test mode0 done");
   endtask

   initial begin
      nrst = 1'b0;
      mode_pin = 1'b1;
      st_a = 1'b0;
      st_b = 1'b0;
      synced = 1'b1;
      repeat (10) @(posedge clock);
      #1 nrst = 1'b1;
      repeat (8) @(posedge clock);
      t_idle;
      t_readback;
      t_status;
      t_queue;
      t_short;
      t_mode0;
      tally_and_finish;
   end
   // whole run needs well under this span
   initial begin
      #100000;
      fail_count++;
      tally_and_finish;
   end
endmodule // scp_port_bench

/* File: rtl/scp_pkg.sv */
// constants and types for the serial control port
package scp_pkg;

   // frame shape
   localparam logic [4:0] BIT_CNT_DONE  = 5'h10;
   localparam logic [4:0] BIT_CNT_LAST  = 5'h0F;
   localparam logic [3:0] TX_MSB        = 4'hF;

   // message field layout, msb first
   localparam int MSG_W       = 16;
   localparam int ADDR_W      = 7;
   localparam int DATA_W      = 8;
   localparam int MSG_ADDR_HI = 15;
   localparam int MSG_ADDR_LO = 9;
   localparam int MSG_RW_BIT  = 8;
   localparam int MSG_DATA_HI = 7;

   // read/write flag meanings
   localparam logic RW_WRITE       = 1'b0;
   localparam logic RW_READ        = 1'b1;
   localparam logic REPLY_READBACK = 1'b1;
   localparam logic REPLY_SPONT    = 1'b0;

   // register file
   localparam int               NUM_REGS   = 128;
   localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
   localparam logic [ADDR_W-1:0] MAINT_ADDR = 7'h38;
   localparam int               LES_A_BIT  = 0;
   localparam int               LES_B_BIT  = 1;

   // outgoing message queue
   localparam int               QDEPTH = 4;
   localparam logic [2:0]       QFULL  = 3'h4;
   localparam logic [2:0]       QNONE  = 3'h0;
   localparam logic [MSG_W-1:0] MSG_ZERO = 16'h0000;

   // strap capture waits out the synchroniser
   localparam logic [1:0] SEL_SETTLE = 2'h3;

   // synchroniser lane order
   localparam int SY_W    = 6;
   localparam int SY_CS   = 0;
   localparam int SY_DONE = 1;
   localparam int SY_SEL  = 2;
   localparam int SY_EXA  = 3;
   localparam int SY_EXB  = 4;
   localparam int SY_LOCK = 5;

   typedef enum logic [3:0] {
      SCP_IDLE  = 4'h1,
      SCP_OFFER = 4'h2,
      SCP_BUSY  = 4'h4,
      SCP_HOLD  = 4'h8
   } scp_state_e;

endpackage

/* File: rtl/scp_port.sv */
// serial control port with interrupt request, device side
//
// Behaviour
// - interface-select pin sampled once after reset, mode then fixed
// - port works only when select pin was high; only path to registers
// - shifting in and out happens only while select input is low
// - serial input captured on each of the first sixteen rising shift clock edges of a frame
// - bit 7 out as select falls, next bits on falling edges
// - full duplex; no pending message means sixteen zero bits out
// - serial output not driven while select is high
// - interrupt asserted for pending message until select goes low
// - no new interrupt while select low; it waits for select high
// - byte one: address bits 7..1, flag bit 0; byte two: data
// - flag zero: second byte written to addressed register
// - flag one: data ignored, content returned later by interrupt
// - outgoing byte one: address, flag 1 read-back, 0 spontaneous
// - when synced, status input changes latch and raise a report
// - shift clock asynchronous; crossings use synchronisers
// - interrupt released on select low, may return after select high
// - several messages queued, one interrupt and one cycle each
`timescale 1ns/100ps
module scp_port (
   // system
   input  wire logic CLOCK,
   input  wire logic NRST,
   // mode strap
   input  wire logic INTERFACE_SELECT_PIN,
   // serial link
   input  wire logic CONTROL_SHIFT_CLOCK,
   input  wire logic SELECT_N,
   input  wire logic SERIAL_CMD_IN,
   output logic      SERIAL_CMD_OUT,
   output logic      SERIAL_CMD_OUT_EN,
   // open-drain interrupt request
   output logic      IRQ_N_OUT,
   output logic      IRQ_N_OE,
   // external status
   input  wire logic EXT_STATUS_IN_A,
   input  wire logic EXT_STATUS_IN_B,
   input  wire logic LINE_SYNCED
);
   import scp_pkg::*;

   // link domain
   logic [4:0]       rise_cnt;
   logic [3:0]       fall_cnt;
   logic [MSG_W-1:0] rx_sh;
   logic [MSG_W-1:0] rx_word;
   logic             frame_done;

   // crossings
   logic [SY_W-1:0]  sy_in;
   logic [SY_W-1:0]  sy_out;
   logic             sel_low;
   logic             done_q;
   logic             done_rise;

   // mode strap
   logic [1:0]       sel_wait;
   logic             sel_taken;
   logic             port_on;

   // received message fields
   logic [ADDR_W-1:0] rx_addr;
   logic              rx_rw;
   logic [DATA_W-1:0] rx_data;
   logic              host_write;
   logic              host_read;

   // register file and status
   logic [DATA_W-1:0] regs [0:NUM_REGS-1];
   logic [1:0]        ext_q;
   logic [1:0]        ext_chg;
   logic              stat_set;

   // pending requests
   logic              stat_pend;
   logic              rb_pend;
   logic [ADDR_W-1:0] rb_addr;

   // queue
   logic [MSG_W-1:0]  q_mem [0:QDEPTH-1];
   logic [1:0]        q_head;
   logic [1:0]        q_tail;
   logic [2:0]        q_cnt;
   logic              push;
   logic              pop;
   logic [MSG_W-1:0]  push_word;

   // offer control
   scp_state_e        state;
   scp_state_e        next_state;
   logic [MSG_W-1:0]  tx_msg;

   // ---------------------------------------------------------------
   // link domain: select high holds the counters at zero, so a
   // stopped clock between frames leaves nothing half done
   // ---------------------------------------------------------------
   always_ff @(posedge CONTROL_SHIFT_CLOCK or posedge SELECT_N) begin
      if (SELECT_N) begin
         rise_cnt   <= 5'h00;
         frame_done <= 1'b0;
      end else if (rise_cnt != BIT_CNT_DONE) begin
         rise_cnt <= rise_cnt + 5'h01;
         if (rise_cnt == BIT_CNT_LAST) begin
            frame_done <= 1'b1;
         end
      end
   end

   // data shift, msb arrives first
   always_ff @(posedge CONTROL_SHIFT_CLOCK) begin
      if (!SELECT_N && rise_cnt != BIT_CNT_DONE) begin
         rx_sh <= {rx_sh[MSG_W-2:0], SERIAL_CMD_IN};
      end
   end

   // whole frame kept stable until the next frame's last edge
   always_ff @(posedge CONTROL_SHIFT_CLOCK) begin
      if (!SELECT_N && rise_cnt == BIT_CNT_LAST) begin
         rx_word <= {rx_sh[MSG_W-2:0], SERIAL_CMD_IN};
      end
   end

   // outgoing bit index moves on falling edges
   always_ff @(negedge CONTROL_SHIFT_CLOCK or posedge SELECT_N) begin
      if (SELECT_N) begin
         fall_cnt <= 4'h0;
      end else begin
         fall_cnt <= fall_cnt + 4'h1;
      end
   end

   // bit 7 of byte one appears with select low, before any edge;
   // tx_msg is quiet while select is low, so it is safe to read here
   assign SERIAL_CMD_OUT = tx_msg[TX_MSB - fall_cnt];
   assign SERIAL_CMD_OUT_EN = !SELECT_N && port_on;

   // ---------------------------------------------------------------
   // crossings into CLOCK
   // ---------------------------------------------------------------
   // carried inverted so the reset value of the flops reads deselected
   assign sy_in[SY_CS]   = !SELECT_N;
   assign sy_in[SY_DONE] = frame_done;
   assign sy_in[SY_SEL]  = INTERFACE_SELECT_PIN;
   assign sy_in[SY_EXA]  = EXT_STATUS_IN_A;
   assign sy_in[SY_EXB]  = EXT_STATUS_IN_B;
   assign sy_in[SY_LOCK] = LINE_SYNCED;

   scp_sync #(
      .W    (SY_W)
   ) u_sync (
      .CLOCK (CLOCK),
      .NRST  (NRST),
      .D     (sy_in),
      .Q     (sy_out)
   );

   assign sel_low = sy_out[SY_CS];

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         done_q <= 1'b0;
      end else begin
         done_q <= sy_out[SY_DONE];
      end
   end

   assign done_rise = sy_out[SY_DONE] && !done_q;

   // ---------------------------------------------------------------
   // strap capture: taken once the synchroniser holds a real level
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         sel_wait  <= 2'h0;
         sel_taken <= 1'b0;
         port_on   <= 1'b0;
      end else if (!sel_taken) begin
         sel_wait <= sel_wait + 2'h1;
         if (sel_wait == SEL_SETTLE) begin
            sel_taken <= 1'b1;
            port_on   <= sy_out[SY_SEL];
         end
      end
   end

   // ---------------------------------------------------------------
   // host message decode
   // ---------------------------------------------------------------
   assign rx_addr = rx_word[MSG_ADDR_HI:MSG_ADDR_LO];
   assign rx_rw   = rx_word[MSG_RW_BIT];
   assign rx_data = rx_word[MSG_DATA_HI:0];

   assign host_write = done_rise && port_on && rx_rw == RW_WRITE;
   assign host_read  = done_rise && port_on && rx_rw == RW_READ;

   // status change, only while the line is fully synchronised
   assign ext_chg  = {sy_out[SY_EXB], sy_out[SY_EXA]} ^ ext_q;
   assign stat_set = port_on && sy_out[SY_LOCK] && (ext_chg != 2'h0);

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         ext_q <= 2'h0;
      end else begin
         ext_q <= {sy_out[SY_EXB], sy_out[SY_EXA]};
      end
   end

   // register file; status bits written after the host so they win
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= REG_RST;
         end
      end else begin
         if (host_write) begin
            regs[rx_addr] <= rx_data;
         end
         if (stat_set) begin
            regs[MAINT_ADDR][LES_A_BIT] <= sy_out[SY_EXA];
            regs[MAINT_ADDR][LES_B_BIT] <= sy_out[SY_EXB];
         end
      end
   end

   // ---------------------------------------------------------------
   // pending reports: a new event in the push cycle is kept
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         stat_pend <= 1'b0;
      end else if (stat_set) begin
         stat_pend <= 1'b1;
      end else if (push && stat_pend) begin
         stat_pend <= 1'b0;
      end
   end

   // one read-back slot; a newer request replaces an unqueued one
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         rb_pend <= 1'b0;
         rb_addr <= '0;
      end else if (host_read) begin
         rb_pend <= 1'b1;
         rb_addr <= rx_addr;
      end else if (push && !stat_pend) begin
         rb_pend <= 1'b0;
      end
   end

   // content is taken when the message enters the queue
   always_comb begin
      if (stat_pend) begin
         push_word = {MAINT_ADDR, REPLY_SPONT, regs[MAINT_ADDR]};
      end else begin
         push_word = {rb_addr, REPLY_READBACK, regs[rb_addr]};
      end
   end

   assign push   = (stat_pend || rb_pend) && q_cnt != QFULL;
   assign pop    = done_rise && state == SCP_BUSY;
   assign q_tail = q_head + q_cnt[1:0];

   // ---------------------------------------------------------------
   // outgoing queue
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         q_head <= 2'h0;
         q_cnt  <= QNONE;
         for (int i = 0; i < QDEPTH; i++) begin
            q_mem[i] <= MSG_ZERO;
         end
      end else begin
         if (push) begin
            q_mem[q_tail] <= push_word;
         end
         if (pop) begin
            q_head <= q_head + 2'h1;
         end
         if (push && !pop) begin
            q_cnt <= q_cnt + 3'h1;
         end else if (pop && !push) begin
            q_cnt <= q_cnt - 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // offer sequencing
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         SCP_IDLE: begin
            if (sel_low) begin
               next_state = SCP_HOLD;
            end else if (port_on && q_cnt != QNONE) begin
               next_state = SCP_OFFER;
            end
         end
         SCP_OFFER: begin
            if (sel_low) begin
               next_state = SCP_BUSY;
            end
         end
         SCP_BUSY: begin
            if (!sel_low) begin
               next_state = SCP_IDLE;
            end
         end
         SCP_HOLD: begin
            if (!sel_low) begin
               next_state = SCP_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         state <= SCP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // request line follows the offer state, from a flop
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         IRQ_N_OE  <= 1'b0;
         IRQ_N_OUT <= 1'b0;
      end else begin
         IRQ_N_OE  <= next_state == SCP_OFFER;
         IRQ_N_OUT <= 1'b0;
      end
   end

   // head loads only with select high; zeros once select is back high,
   // so an unprompted cycle shifts out all zeros; clearing at the pop
   // would move the line while the host still holds the last bit
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         tx_msg <= MSG_ZERO;
      end else if (state == SCP_IDLE && next_state == SCP_OFFER) begin
         tx_msg <= q_mem[q_head];
      end else if (state == SCP_BUSY && next_state == SCP_IDLE) begin
         tx_msg <= MSG_ZERO;
      end
   end

endmodule // scp_port

/* File: rtl/scp_sync.sv */
// two-flop level synchroniser into the CLOCK domain
`timescale 1ns/100ps
module scp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         CLOCK,
   input  wire logic         NRST,
   // levels
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);

   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         meta <= '0;
         Q    <= '0;
      end else begin
         meta <= D;
         Q    <= meta;
      end
   end

endmodule // scp_sync
